// >>> rtl/adc_wrap_pkg.sv
// Purpose: constants and carrier types of the converter wrapper register bank
// Assumes: 32-bit APB, printed offsets are word indices (byte address = 4 * index)
// Notes:   most numbers used by the wrapper live here; the select write mask stays inline
package adc_wrap_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [6:0] IDX_CTRL    = 7'h00; // converter_control_status
  localparam logic [6:0] IDX_MODE    = 7'h01; // converter_mode_clock
  localparam logic [6:0] IDX_FLG     = 7'h03; // interrupt_flags
  localparam logic [6:0] IDX_FLGCLR  = 7'h04; // interrupt_flag_clear
  localparam logic [6:0] IDX_OVF     = 7'h05; // interrupt_overflow_flags
  localparam logic [6:0] IDX_OVFCLR  = 7'h06; // overflow clear, reads 0
  localparam logic [6:0] IDX_SEL12   = 7'h07; // source select irq one/two
  localparam logic [6:0] IDX_SEL34   = 7'h08; // source select irq three/four
  localparam logic [6:0] IDX_STAT    = 7'h10; // sticky event status
  localparam logic [6:0] IDX_MASK    = 7'h11; // event mask

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BUSY     = 13;
  localparam int BIT_SLOT_LO  = 8;
  localparam int BIT_POWER    = 7;
  localparam int BIT_PULSEPOS = 2;
  localparam int BIT_DIFF     = 7;
  localparam int BIT_RES16    = 6;
  localparam int BIT_CONT     = 6;   // within each select byte
  localparam int BIT_EN       = 5;
  localparam int SEL_HI_LO    = 8;   // second channel's byte

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG16   = 16'h0000;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [3:0]  DIV_INVALID = 4'h1;
  localparam logic [4:0]  HALF_STEP   = 5'h02;  // accumulator step, half units
  localparam logic [4:0]  DIV_OFFSET  = 5'h02;  // code k -> (k + 2) half units
  localparam logic [2:0]  BUSY_TAIL   = 3'h4;   // conversion clocks after S/H fall

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_TAIL   = 3'b100
  } conv_st_e;

  typedef struct packed {
    logic       cont;   // irq_repeat_mode
    logic       en;     // channel enable
    logic [3:0] sel;    // irq_source_select
  } irq_cfg_s;

endpackage

// >>> rtl/adc_wrap_regs.sv
// Purpose: control, status and interrupt flag bank of a SAR converter wrapper
// Assumes: single clock pclk, analog core handshakes are on the same clock
// Notes:   zero-wait APB slave, answer in the access cycle
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module adc_wrap_regs (
  // bus clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // conversion engine side
  input  wire logic        soc_req,
  input  wire logic [3:0]  soc_slot,
  input  wire logic        sample_hold,
  output logic             soc_ready,
  output logic             conv_start,
  output logic             conversion_clock,
  output logic             eoc_pulse,
  output logic [3:0]       eoc_slot,
  output logic             result_latch,
  // analog core controls
  output logic             analog_power_on,
  output logic             differential_select,
  output logic             resolution_16b,
  // interrupts
  output logic [3:0]       irq_pulse,
  output logic             irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       setup;    // setup phase of a transfer
  logic       wr;       // write taken this cycle
  logic [6:0] idx;      // word index
  logic       hit;      // index maps to a register
  logic       aligned;  // low two and top three address bits zero

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pready & pwrite & ~pslverr;
  assign idx     = paddr[8:2];
  assign aligned = (paddr[1:0] == 2'b00) & (paddr[11:9] == 3'b000);
  always_comb begin
    case (idx)
      adc_wrap_pkg::IDX_CTRL,  adc_wrap_pkg::IDX_MODE,
      adc_wrap_pkg::IDX_FLG,   adc_wrap_pkg::IDX_FLGCLR,
      adc_wrap_pkg::IDX_OVF,   adc_wrap_pkg::IDX_OVFCLR,
      adc_wrap_pkg::IDX_SEL12, adc_wrap_pkg::IDX_SEL34,
      adc_wrap_pkg::IDX_STAT,  adc_wrap_pkg::IDX_MASK: hit = aligned;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // software-written fields
  // ----------------------------------------------------------------
  logic        pwr_q;       // analog power enable
  logic        pulsepos_q;  // 0 acquisition end, 1 conversion end
  logic        diff_q;      // differential input
  logic        res16_q;     // 16-bit resolution
  logic [3:0]  div_q;       // conversion clock divider code
  logic [15:0] sel12_q;     // select for irq one and two
  logic [15:0] sel34_q;     // select for irq three and four
  logic [7:0]  mask_q;      // event mask

  // control writes; only defined bits are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q      <= 1'b0;
      pulsepos_q <= 1'b0;
      diff_q     <= 1'b0;
      res16_q    <= 1'b0;
      div_q      <= 4'h0;
      sel12_q    <= adc_wrap_pkg::RST_REG16;
      sel34_q    <= adc_wrap_pkg::RST_REG16;
      mask_q     <= 8'h00;
    end else if (wr) begin
      case (idx)
        adc_wrap_pkg::IDX_CTRL: begin
          pwr_q      <= pwdata[adc_wrap_pkg::BIT_POWER];
          pulsepos_q <= pwdata[adc_wrap_pkg::BIT_PULSEPOS];
        end
        adc_wrap_pkg::IDX_MODE: begin
          diff_q  <= pwdata[adc_wrap_pkg::BIT_DIFF];
          res16_q <= pwdata[adc_wrap_pkg::BIT_RES16];
          div_q   <= pwdata[3:0];
        end
        adc_wrap_pkg::IDX_SEL12: sel12_q <= pwdata[15:0] & 16'h6F6F;
        adc_wrap_pkg::IDX_SEL34: sel34_q <= pwdata[15:0] & 16'h6F6F;
        adc_wrap_pkg::IDX_MASK:  mask_q  <= pwdata[7:0];
        default: ;  // flag/clear registers handled elsewhere
      endcase
    end
  end

  // analog core levels registered from the stored bits, one cycle behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_power_on     <= 1'b0;
      differential_select <= 1'b0;
      resolution_16b      <= 1'b0;
    end else begin
      analog_power_on     <= pwr_q;
      differential_select <= diff_q;
      resolution_16b      <= res16_q;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  // half-unit accumulator gives x.5 ratios; those ratios jitter by a
  // cycle but average right, traded for no second clock domain
  logic [4:0] acc_q;   // accumulated half units
  logic [4:0] tgt;     // ratio in half units
  logic [4:0] acc_n;   // accumulator plus step
  logic       tick;    // one conversion clock period done

  always_comb begin
    if (div_q == 4'h0 || div_q == adc_wrap_pkg::DIV_INVALID)
      tgt = adc_wrap_pkg::HALF_STEP;  // invalid code runs as /1
    else
      tgt = {1'b0, div_q} + adc_wrap_pkg::DIV_OFFSET;
    acc_n = acc_q + adc_wrap_pkg::HALF_STEP;
    tick  = pwr_q & (acc_n >= tgt);
  end

  // accumulator; held at zero while powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q            <= 5'h00;
      conversion_clock <= 1'b0;
    end else begin
      if (!pwr_q)
        acc_q <= 5'h00;
      else if (tick)
        acc_q <= acc_n - tgt;
      else
        acc_q <= acc_n;
      conversion_clock <= tick;
    end
  end

  // ----------------------------------------------------------------
  // busy tracking
  // ----------------------------------------------------------------
  adc_wrap_pkg::conv_st_e st_q;  // sequence state
  adc_wrap_pkg::conv_st_e st_d;
  logic [2:0] tail_q;   // conversion clocks since S/H fall
  logic [3:0] slot_q;   // busy_slot_index
  logic       sh_q;     // previous S/H level
  logic       sh_fall;  // end of acquisition window
  logic       accept;   // trigger taken
  logic       done;     // end of conversion
  logic       done_q;   // end of conversion, one cycle old
  logic       busy;

  assign sh_fall = sh_q & ~sample_hold;
  assign accept  = soc_req & soc_ready;
  assign done    = (st_q == adc_wrap_pkg::ST_TAIL) & tick &
                   (tail_q == adc_wrap_pkg::BUSY_TAIL - 3'h1);
  assign busy    = (st_q != adc_wrap_pkg::ST_IDLE);

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      adc_wrap_pkg::ST_IDLE:   if (accept) st_d = adc_wrap_pkg::ST_SAMPLE;
      adc_wrap_pkg::ST_SAMPLE: if (sh_fall) st_d = adc_wrap_pkg::ST_TAIL;
      adc_wrap_pkg::ST_TAIL:   if (done) st_d = adc_wrap_pkg::ST_IDLE;
      default:                 st_d = adc_wrap_pkg::ST_IDLE;
    endcase
  end

  // state, tail count, slot capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= adc_wrap_pkg::ST_IDLE;
      tail_q <= 3'h0;
      slot_q <= 4'h0;
      sh_q   <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sample_hold;
      if (st_q != adc_wrap_pkg::ST_TAIL)
        tail_q <= 3'h0;
      else if (tick)
        tail_q <= tail_q + 3'h1;
      if (accept)
        slot_q <= soc_slot;       // kept after busy drops
    end
  end

  // engine-facing pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soc_ready    <= 1'b0;
      conv_start   <= 1'b0;
      eoc_pulse    <= 1'b0;
      eoc_slot     <= 4'h0;
      done_q       <= 1'b0;
      result_latch <= 1'b0;
    end else begin
      // refused while busy or powered down
      soc_ready  <= (st_d == adc_wrap_pkg::ST_IDLE) & pwr_q;
      conv_start <= accept;
      // early pulse at S/H fall, late one at conversion end
      eoc_pulse  <= pulsepos_q ? done : ((st_q == adc_wrap_pkg::ST_SAMPLE) & sh_fall);
      eoc_slot   <= slot_q;
      // result waits one cycle behind the late pulse, never lands with it
      done_q       <= done;
      result_latch <= done_q;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  logic [3:0] flg_q;    // interrupt_flags
  logic [3:0] ovf_q;    // interrupt_overflow_flags
  logic [3:0] iset;     // selected done event per channel
  logic [3:0] fclr;     // software clear of flag
  logic [3:0] oclr;     // software clear of overflow
  logic [3:0] ipls;     // pulse to generate
  logic [3:0] oset;     // overflow event
  logic [15:0] eoc_vec; // one-hot done slot

  assign eoc_vec = eoc_pulse ? (16'h0001 << eoc_slot) : 16'h0000;
  assign fclr = (wr && idx == adc_wrap_pkg::IDX_FLGCLR) ? pwdata[3:0] : 4'h0;
  assign oclr = (wr && idx == adc_wrap_pkg::IDX_OVFCLR) ? pwdata[3:0] : 4'h0;

  generate
    for (genvar n = 0; n < 4; n++) begin : g_irq
      adc_wrap_pkg::irq_cfg_s cfg;  // this channel's select byte
      logic [15:0] sbyte;
      assign sbyte = (n < 2) ? sel12_q : sel34_q;
      assign cfg = '{cont: sbyte[(n % 2) * adc_wrap_pkg::SEL_HI_LO + adc_wrap_pkg::BIT_CONT],
                     en:   sbyte[(n % 2) * adc_wrap_pkg::SEL_HI_LO + adc_wrap_pkg::BIT_EN],
                     sel:  sbyte[(n % 2) * adc_wrap_pkg::SEL_HI_LO +: 4]};
      assign iset[n] = cfg.en & eoc_vec[cfg.sel];
      assign ipls[n] = iset[n] & (cfg.cont | ~flg_q[n]);
      // overflow not touched when a clear lands with the set
      assign oset[n] = iset[n] & flg_q[n] & ~fclr[n];

      // flag: hardware set wins over clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flg_q[n] <= 1'b0;
          ovf_q[n] <= 1'b0;
        end else begin
          if (iset[n])
            flg_q[n] <= 1'b1;
          else if (fclr[n])
            flg_q[n] <= 1'b0;
          if (oset[n])
            ovf_q[n] <= 1'b1;
          else if (oclr[n])
            ovf_q[n] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sticky status, mask, interrupt line
  // ----------------------------------------------------------------
  logic [7:0] stat_q;   // [3:0] pulses, [7:4] overflows
  logic [7:0] sset;
  logic [7:0] sclr;

  assign sset = {oset, ipls};
  assign sclr = (wr && idx == adc_wrap_pkg::IDX_STAT) ? pwdata[7:0] : 8'h00;

  // set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q    <= 8'h00;
      irq_pulse <= 4'h0;
      irq       <= 1'b0;
    end else begin
      stat_q    <= sset | (stat_q & ~sclr);
      irq_pulse <= ipls;
      irq       <= |((sset | (stat_q & ~sclr)) & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------
  logic [31:0] rdat;
  always_comb begin
    rdat = adc_wrap_pkg::RST_WORD;  // clear registers read 0
    case (idx)
      adc_wrap_pkg::IDX_CTRL: begin
        rdat[adc_wrap_pkg::BIT_BUSY]           = busy;
        rdat[adc_wrap_pkg::BIT_SLOT_LO +: 4]   = slot_q;
        rdat[adc_wrap_pkg::BIT_POWER]          = pwr_q;
        rdat[adc_wrap_pkg::BIT_PULSEPOS]       = pulsepos_q;
      end
      adc_wrap_pkg::IDX_MODE: begin
        rdat[adc_wrap_pkg::BIT_DIFF]  = diff_q;
        rdat[adc_wrap_pkg::BIT_RES16] = res16_q;
        rdat[3:0]                     = div_q;
      end
      adc_wrap_pkg::IDX_FLG:   rdat[3:0]  = flg_q;
      adc_wrap_pkg::IDX_OVF:   rdat[3:0]  = ovf_q;
      adc_wrap_pkg::IDX_SEL12: rdat[15:0] = sel12_q;
      adc_wrap_pkg::IDX_SEL34: rdat[15:0] = sel34_q;
      adc_wrap_pkg::IDX_STAT:  rdat[7:0]  = stat_q;
      adc_wrap_pkg::IDX_MASK:  rdat[7:0]  = mask_q;
      default: ;
    endcase
  end

  // answer registered in setup, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= adc_wrap_pkg::RST_WORD;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & hit & ~pwrite) ? rdat : adc_wrap_pkg::RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_on_accept: assert property (accept |=> busy)
    else $error("busy not set after trigger");
  a_busy_refuse: assert property (busy && soc_req |-> !accept)
    else $error("trigger taken while busy");
  a_tail_four: assert property (sh_fall && st_q == adc_wrap_pkg::ST_SAMPLE && pwr_q && div_q == 4'h0
                                |=> busy [*4] ##1 !busy)
    else $error("busy cleared early");
  a_slot_hold: assert property (!accept |=> slot_q == $past(slot_q))
    else $error("slot index moved without trigger");
  a_late_pulse: assert property (done && pulsepos_q |=> eoc_pulse && !result_latch ##1 result_latch)
    else $error("late done pulse missing");
  a_result_after: assert property (done |=> !result_latch ##1 result_latch ##1 !result_latch)
    else $error("result latch timing wrong");
  a_set_wins: assert property (iset[0] && fclr[0] |=> flg_q[0])
    else $error("clear beat hardware set");
  a_ovf_kept: assert property (iset[0] && fclr[0] |=> ovf_q[0] == $past(ovf_q[0]))
    else $error("overflow touched on clear collision");
  a_no_repeat: assert property (iset[0] && flg_q[0] && !g_irq[0].cfg.cont |=> !irq_pulse[0] && ovf_q[0])
    else $error("pulse not suppressed");
  a_clear_flag: assert property (fclr[0] && !iset[0] |=> !flg_q[0])
    else $error("flag clear ignored");
  a_clr_reads_zero: assert property (setup && !pwrite && idx == adc_wrap_pkg::IDX_FLGCLR |=> prdata == 32'h0000_0000)
    else $error("clear register read nonzero");

endmodule // adc_wrap_regs

// >>> tb/conv_core_model.sv
// Purpose: stand-in for the analog conversion core, drives the sample-and-hold level
// Assumes: same clock as the wrapper, start pulse is one cycle long
// Notes:   acquisition length is fixed by SH_CYC, long enough for a register read
`timescale 1ns/1ps
module conv_core_model #(
  parameter int SH_CYC = 12  // acquisition window in cycles
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // wrapper handshake
  input  wire logic conv_start,
  output logic      sample_hold
);
  int cnt_q;  // acquisition cycles still to run

  // ----------------------------------------------------------------
  // acquisition window
  // ----------------------------------------------------------------
  // idle low; rises on start, its fall ends acquisition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= 0;
      sample_hold <= 1'b0;
    end else if (conv_start) begin
      cnt_q       <= SH_CYC;
      sample_hold <= 1'b1;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end else begin
      cnt_q       <= 0;
      sample_hold <= 1'b0;
    end
  end
endmodule // conv_core_model

// >>> tb/test_adc_wrapper_ctrl_irq_flags.sv
// Purpose: self-checking bench of the converter wrapper register bank
// Assumes: zero-wait apb slave, conversion core model on the far side
// Notes:   divider counts assume a free-running conversion clock tick
`timescale 1ns/1ps
module test_adc_wrapper_ctrl_irq_flags;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite;  // bus control
  logic [11:0] paddr;                                 // byte address
  logic [31:0] pwdata, prdata;                        // bus data
  logic        pready, pslverr;                       // slave answer
  logic        soc_req, sample_hold, soc_ready, conv_start;
  logic [3:0]  soc_slot, eoc_slot, irq_pulse;         // slot indices, pulses
  logic        conversion_clock, eoc_pulse, result_latch;
  logic        analog_power_on, differential_select, resolution_16b, irq;
  int          miscompares = 0;                       // mismatches seen
  int          checked = 0;                           // comparisons made
  int          cyc = 0, sh_fall = 0, eoc_dly = 0;     // timing monitor
  int          eoc_cnt = 0, irq0_cnt = 0, ticks = 0;  // event counters
  int          eoc_at = 0, res_dly = 0;               // pulse-to-result gap
  logic        sh_d = 1'b0;                           // s/h one edge ago

  adc_wrap_regs u_adc_wrap_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .soc_req(soc_req), .soc_slot(soc_slot), .sample_hold(sample_hold),
    .soc_ready(soc_ready), .conv_start(conv_start), .conversion_clock(conversion_clock),
    .eoc_pulse(eoc_pulse), .eoc_slot(eoc_slot), .result_latch(result_latch),
    .analog_power_on(analog_power_on), .differential_select(differential_select),
    .resolution_16b(resolution_16b), .irq_pulse(irq_pulse), .irq(irq));
  conv_core_model u_conv_core_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .sample_hold(sample_hold));

  // ----------------------------------------------------------------
  // clock and monitors
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // counts events on pre-edge values, so design updates never race it
  always @(posedge pclk) begin
    cyc  <= cyc + 1;
    sh_d <= sample_hold;
    if (sh_d && !sample_hold) sh_fall <= cyc;
    if (eoc_pulse) begin
      eoc_cnt <= eoc_cnt + 1;
      eoc_dly <= cyc - sh_fall;
      eoc_at  <= cyc;
    end
    if (result_latch) res_dly <= cyc - eoc_at;
    if (irq_pulse[0]) irq0_cnt <= irq0_cnt + 1;
    if (conversion_clock) ticks <= ticks + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, {3'b000, idx, 2'b00}, wd, d, e);
    chkb(e, 1'b0);
  endtask
  task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, {3'b000, idx, 2'b00}, 32'h0000_0000, d, e);
    chk(d, exp);
    chkb(e, 1'b0);
  endtask
  // trigger is held one cycle; it is taken only when soc_ready is high
  task automatic trig(input logic [3:0] slot);
    @(posedge pclk);
    soc_req  <= 1'b1;
    soc_slot <= slot;
    @(posedge pclk);
    soc_req <= 1'b0;
  endtask
  // unbounded wait for the engine to be ready again, then let flags land
  task automatic conv(input logic [3:0] slot);
    trig(slot);
    repeat (2) @(posedge pclk);
    while (soc_ready !== 1'b1) begin
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset_and_regs();
    logic [31:0] d;
    logic        e;
    rdc(adc_wrap_pkg::IDX_CTRL, 32'h0000_0000);
    rdc(adc_wrap_pkg::IDX_MODE, 32'h0000_0000);
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0000);
    chkb(analog_power_on, 1'b0);
    wr(adc_wrap_pkg::IDX_MODE, 32'hFFFF_FFFF);
    rdc(adc_wrap_pkg::IDX_MODE, 32'h0000_00CF);
    chkb(differential_select, 1'b1);
    chkb(resolution_16b, 1'b1);
    wr(adc_wrap_pkg::IDX_MODE, 32'h0000_0000);     // back to /1 for the conversions
    wr(adc_wrap_pkg::IDX_FLG, 32'h0000_000F);      // read-only place
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000, d, e);       // unmapped word
    chk({d[31:1], e}, 32'h0000_0001);
    wr(adc_wrap_pkg::IDX_CTRL, 32'hFFFF_FFFF);
    rdc(adc_wrap_pkg::IDX_CTRL, 32'h0000_0084);
    chkb(analog_power_on, 1'b1);
    wr(adc_wrap_pkg::IDX_CTRL, 32'h0000_0080);     // early pulse position
  endtask
  task automatic s_conv_and_flags();
    wr(adc_wrap_pkg::IDX_SEL12, 32'h0000_0025);    // irq one on slot 5
    conv(4'h3);                                    // unselected slot
    chk(irq0_cnt, 32'h0000_0000);
    trig(4'h5);
    rdc(adc_wrap_pkg::IDX_CTRL, 32'h0000_2580);
    trig(4'h9);                                    // refused while busy
    conv(4'h9);                                    // refused again, then wait
    rdc(adc_wrap_pkg::IDX_CTRL, 32'h0000_0580);
    chk(eoc_cnt, 32'h0000_0002);
    chk(eoc_dly, 32'h0000_0001);
    chk(irq0_cnt, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_STAT, 32'h0000_0001);
    chkb(irq, 1'b0);
    wr(adc_wrap_pkg::IDX_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chkb(irq, 1'b1);
  endtask
  task automatic s_overflow_and_clear();
    conv(4'h5);
    chk(irq0_cnt, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_OVF, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_FLGCLR, 32'h0000_0000);
    wr(adc_wrap_pkg::IDX_FLGCLR, 32'h0000_000E);
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0001);
    wr(adc_wrap_pkg::IDX_FLGCLR, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0000);
    rdc(adc_wrap_pkg::IDX_STAT, 32'h0000_0011);
    wr(adc_wrap_pkg::IDX_STAT, 32'h0000_00FF);
    rdc(adc_wrap_pkg::IDX_STAT, 32'h0000_0000);
    chkb(irq, 1'b0);
    wr(adc_wrap_pkg::IDX_SEL12, 32'h0000_0065);    // repeat mode on
    conv(4'h5);
    conv(4'h5);
    chk(irq0_cnt, 32'h0000_0003);
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0001);
  endtask
  // clear write timed onto the done event: trigger edge + 15, with a 12-cycle window
  task automatic s_set_clear_collision();
    wr(adc_wrap_pkg::IDX_OVFCLR, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_OVF, 32'h0000_0000);
    trig(4'h5);                                    // flag still set
    repeat (12) @(posedge pclk);
    wr(adc_wrap_pkg::IDX_FLGCLR, 32'h0000_0001);   // lands with the hardware set
    rdc(adc_wrap_pkg::IDX_FLG, 32'h0000_0001);
    rdc(adc_wrap_pkg::IDX_OVF, 32'h0000_0000);
    repeat (4) @(posedge pclk);
  endtask
  task automatic s_late_and_divider();
    int t0;
    int exp_ticks[5] = '{40, 40, 20, 16, 10};      // /1, invalid, /2, /2.5, /4 over 40
    logic [3:0] code[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6};
    wr(adc_wrap_pkg::IDX_CTRL, 32'h0000_0084);
    conv(4'h5);
    chkb(eoc_dly > 3, 1'b1);
    chkb(res_dly > 0 && res_dly < 5, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(adc_wrap_pkg::IDX_MODE, {28'h000_0000, code[i]});
      repeat (10) @(posedge pclk);
      t0 = ticks;
      repeat (40) @(posedge pclk);
      chk(ticks - t0, exp_ticks[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #50_000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, soc_req} = 5'b00000;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    soc_slot = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_reset_and_regs();
    s_conv_and_flags();
    s_overflow_and_clear();
    s_set_clear_collision();
    s_late_and_divider();
    tally_and_finish();
  end
endmodule // test_adc_wrapper_ctrl_irq_flags
